// file: hw/rfd_pkg.sv
// rfd_pkg: constants, field layouts and types for the instruction field decoder
// assumes a 40 MHz core clock and a single AHB-Lite master for the registers
package rfd_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_CAUSE  = 8'h04;
	localparam logic [7:0] ADDR_ISTAT  = 8'h08;
	localparam logic [7:0] ADDR_ICLR   = 8'h0c;
	localparam logic [7:0] ADDR_IEN    = 8'h10;
	localparam logic [7:0] ADDR_LAST   = 8'h14;
	localparam int         CTRL_EN_BIT = 0;
	localparam logic       CTRL_RST    = 1'b1;
	localparam int         CAUSE_LSB   = 16;
	localparam int         NUM_EV      = 5;
	// ----------------------------------------
	// event bit positions, also cause priority order
	// ----------------------------------------
	localparam int EV_UNIMPL = 0;
	localparam int EV_SWI    = 1;
	localparam int EV_UNALGN = 2;
	localparam int EV_ILLEG  = 3;
	localparam int EV_FPU    = 4;
	// ----------------------------------------
	// exception cause codes per generation
	// ----------------------------------------
	localparam logic [3:0] G0_UNIMPL = 4'h4;
	localparam logic [3:0] G0_SWI    = 4'h1;
	localparam logic [3:0] G0_UNALGN = 4'h2;
	localparam logic [3:0] G0_ILLEG  = 4'h5;
	localparam logic [3:0] G0_FPU    = 4'h3;
	localparam logic [3:0] G1_UNIMPL = 4'hf;
	localparam logic [3:0] G1_SWI    = 4'he;
	localparam logic [3:0] G1_UNALGN = 4'hd;
	localparam logic [3:0] G1_ILLEG  = 4'hc;
	localparam logic [3:0] G1_FPU    = 4'h7;
	// ----------------------------------------
	// instruction word fields
	// ----------------------------------------
	localparam int LONG_BIT   = 3;
	localparam int STORE_BIT  = 4;
	localparam int SIZE_LSB   = 5;
	localparam int SUB_BIT    = 20;
	localparam int SHIFT_LSB  = 5;
	localparam int COND_LSB   = 4;
	localparam int DISP_LSB   = 8;
	localparam int MOVC_SPEC  = 8;
	localparam int GRP_LSB    = 20;
	localparam int SYS_LSB    = 4;
	localparam int ALU_LSB    = 16;
	localparam logic [3:0] ALU_EXT  = 4'ha;
	localparam logic [5:0] SYS_TRAP = 6'h3e;
	localparam logic [5:0] SYS_MAX  = 6'h09;
	// ----------------------------------------
	// access sizes and special register groups
	// ----------------------------------------
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_DBL  = 2'h3;
	localparam logic [11:0] GRP_BASE_CORE = 12'hf04;
	localparam logic [11:0] GRP_BASE_DMA  = 12'hf05;
	localparam logic [11:0] GRP_BASE_MPU  = 12'hf06;
	localparam logic [11:0] GRP_BASE_NODE = 12'hf07;

	typedef enum logic [2:0] {
		CL_BRANCH, CL_LS_IDX, CL_MOVC, CL_IMM_ALU,
		CL_LS_DISP, CL_REG_ALU, CL_SHIFT, CL_FPU
	} rfd_class_t;

	typedef struct packed {
		logic        valid;
		logic        is_long;
		rfd_class_t  iclass;
		logic        is_mem;
		logic        is_store;
		logic        subtract;
		logic [1:0]  access_size_field;
		logic [4:0]  shift_amount_imm;
		logic [23:0] branch_displacement;
		logic [3:0]  condition_select;
		logic        is_special;
		logic [1:0]  special_reg_group;
		logic [11:0] special_base;
	} rfd_dec_t;
endpackage : rfd_pkg

// file: hw/rfd_decoder.sv
// rfd_decoder: instruction field decoder with exception cause and AHB-Lite registers
// assumes fetch drives words on MCLK and the pipeline consumes the decoded word one cycle later
//
// What this block does
// RQ1: sub field one subtracts, zero adds
// RQ2: direction bit one stores, zero loads
// RQ3: size 00 byte, 11 double transfers
// RQ4: group field picks core, dma, protection, node
// RQ5: five bit shift amount to shifter
// RQ6: branch displacement up to 24 bits
// RQ7: four bit condition select for branches, moves
// RQ8: earlier generation cause codes 4,1,2,5,3
// RQ9: later generation cause codes f,e,d,c,7
// RQ10: generation parameter; undefined words raise unimplemented
// RQ11: length from low opcode bits
`timescale 1ns/1ps
`default_nettype none
module rfd_decoder
	import rfd_pkg::*;
#(
	parameter bit GEN = 1'b0
) (
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output var  logic [31:0] HRDATA,
	output var  logic        HREADYOUT,
	output var  logic        HRESP,
	input  wire logic [31:0] INSTR_WORD,
	input  wire logic        INSTR_VALID,
	input  wire logic        UNALIGNED_EV,
	input  wire logic        ILLEGAL_EV,
	input  wire logic        FPU_EV,
	output var  rfd_dec_t    DECODED,
	output var  logic        EXC_VALID,
	output var  logic [3:0]  EXC_CAUSE,
	output var  logic        IRQ
);
	// ----------------------------------------
	// functions
	// ----------------------------------------
	function automatic rfd_dec_t decode_f(input logic [31:0] w);
		rfd_dec_t d;
		d = '0;
		d.is_long  = w[LONG_BIT]; // see RQ11
		d.iclass   = rfd_class_t'(w[2:0]);
		d.is_mem   = (d.iclass == CL_LS_IDX) || (d.iclass == CL_LS_DISP);
		d.is_store = d.is_mem & w[STORE_BIT]; // see RQ2
		d.subtract = d.is_mem & d.is_long & w[SUB_BIT]; // see RQ1
		if (d.is_mem) begin
			d.access_size_field = w[SIZE_LSB +: 2]; // see RQ3
		end
		if (d.iclass == CL_SHIFT) begin
			d.shift_amount_imm = w[SHIFT_LSB +: 5]; // see RQ5
		end
		if (d.iclass == CL_BRANCH) begin
			d.branch_displacement = d.is_long ? w[DISP_LSB +: 24] : {16'h0000, w[DISP_LSB +: 8]}; // see RQ6
		end
		if (d.iclass == CL_BRANCH || (d.iclass == CL_MOVC && !w[MOVC_SPEC])) begin
			d.condition_select = w[COND_LSB +: 4]; // see RQ7
		end
		if (d.iclass == CL_MOVC && w[MOVC_SPEC]) begin
			d.is_special = 1'b1;
			d.special_reg_group = d.is_long ? w[GRP_LSB +: 2] : 2'h0; // see RQ4
			d.special_base = group_base_f(d.special_reg_group);
		end
		return d;
	endfunction : decode_f

	function automatic logic [11:0] group_base_f(input logic [1:0] g);
		case (g) // see RQ4
			2'h0: group_base_f = GRP_BASE_CORE;
			2'h1: group_base_f = GRP_BASE_DMA;
			2'h2: group_base_f = GRP_BASE_MPU;
			default: group_base_f = GRP_BASE_NODE;
		endcase
	endfunction : group_base_f

	// short system words share the movc class with both mark bits set
	function automatic logic is_sys_f(input logic [31:0] w);
		return (w[3:0] == 4'h2) && (w[9:8] == 2'h3);
	endfunction : is_sys_f

	function automatic logic undefined_f(input logic [31:0] w);
		logic bad;
		bad = 1'b0;
		if (is_sys_f(w) && w[SYS_LSB +: 6] != SYS_TRAP && w[SYS_LSB +: 6] > SYS_MAX) begin
			bad = 1'b1;
		end
		if (w[LONG_BIT] && w[2:0] == CL_REG_ALU && w[ALU_LSB +: 4] != ALU_EXT) begin
			bad = 1'b1;
		end
		return bad; // see RQ10
	endfunction : undefined_f

	function automatic logic [3:0] cause_code_f(input bit g, input int ev);
		logic [3:0] c;
		c = 4'h0;
		case (ev)
			EV_UNIMPL: c = g ? G1_UNIMPL : G0_UNIMPL; // see RQ8, see RQ9
			EV_SWI:    c = g ? G1_SWI    : G0_SWI;
			EV_UNALGN: c = g ? G1_UNALGN : G0_UNALGN;
			EV_ILLEG:  c = g ? G1_ILLEG  : G0_ILLEG;
			default:   c = g ? G1_FPU    : G0_FPU;
		endcase
		return c;
	endfunction : cause_code_f

	// ----------------------------------------
	// registers and bus capture
	// ----------------------------------------
	logic                ctrl_en_q;
	logic [NUM_EV-1:0]   ist_q;
	logic [NUM_EV-1:0]   ien_q;
	logic [31:0]         last_q;
	logic                wr_pend_q;
	logic [7:0]          wr_addr_q;
	logic [NUM_EV-1:0]   ev_d;
	logic [3:0]          cause_d;
	logic                take_instr;
	logic                addr_ok;
	logic [31:0]         rd_d;

	assign take_instr = INSTR_VALID && ctrl_en_q;
	assign addr_ok    = HSEL && HTRANS[1] && HREADY;

	// zero wait states: HREADYOUT is low in reset and high from the first edge after it, writes land in the data phase
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
		end else if (HREADY) begin
			wr_pend_q <= addr_ok && HWRITE;
			wr_addr_q <= HADDR[7:0];
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			HREADYOUT <= 1'b0;
			HRESP     <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP     <= 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_en_q <= CTRL_RST;
			ien_q     <= '0;
		end else if (wr_pend_q) begin
			if (wr_addr_q == ADDR_CTRL) begin
				ctrl_en_q <= HWDATA[CTRL_EN_BIT];
			end
			if (wr_addr_q == ADDR_IEN) begin
				ien_q <= HWDATA[NUM_EV-1:0];
			end
		end
	end

	// read data is fetched in the address phase so HRDATA is a flop
	always_comb begin
		rd_d = 32'h0000_0000;
		case (HADDR[7:0])
			ADDR_CTRL:  rd_d[CTRL_EN_BIT] = ctrl_en_q;
			ADDR_CAUSE: rd_d[CAUSE_LSB +: 4] = EXC_CAUSE;
			ADDR_ISTAT: rd_d[NUM_EV-1:0] = ist_q;
			ADDR_IEN:   rd_d[NUM_EV-1:0] = ien_q;
			ADDR_LAST:  rd_d = last_q;
			default:    rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA <= 32'h0000_0000;
		end else if (addr_ok && !HWRITE) begin
			HRDATA <= rd_d;
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			DECODED <= '0;
			last_q  <= 32'h0000_0000;
		end else begin
			DECODED       <= take_instr ? decode_f(INSTR_WORD) : '0;
			DECODED.valid <= take_instr;
			if (take_instr) begin
				last_q <= INSTR_WORD;
			end
		end
	end

	// ----------------------------------------
	// exceptions and interrupt
	// ----------------------------------------
	always_comb begin
		ev_d            = '0;
		ev_d[EV_UNIMPL] = take_instr && undefined_f(INSTR_WORD); // see RQ10
		ev_d[EV_SWI]    = take_instr && is_sys_f(INSTR_WORD) && INSTR_WORD[SYS_LSB +: 6] == SYS_TRAP;
		ev_d[EV_UNALGN] = UNALIGNED_EV;
		ev_d[EV_ILLEG]  = ILLEGAL_EV;
		ev_d[EV_FPU]    = FPU_EV;
	end

	// lowest event index wins when several arrive together
	always_comb begin
		cause_d = 4'h0;
		for (int i = NUM_EV - 1; i >= 0; i--) begin
			if (ev_d[i]) begin
				cause_d = cause_code_f(GEN, i); // see RQ8, see RQ9
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			EXC_VALID <= 1'b0;
			EXC_CAUSE <= 4'h0;
		end else begin
			EXC_VALID <= |ev_d;
			if (|ev_d) begin
				EXC_CAUSE <= cause_d;
			end
		end
	end

	// a new event beats a clear in the same cycle
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ist_q <= '0;
		end else if (wr_pend_q && wr_addr_q == ADDR_ICLR) begin
			ist_q <= (ist_q & ~HWDATA[NUM_EV-1:0]) | ev_d;
		end else begin
			ist_q <= ist_q | ev_d;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(ist_q & ien_q);
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	a_sub_direction: assert property ( // see RQ1
		take_instr && INSTR_WORD[2:0] == 3'h4 && INSTR_WORD[LONG_BIT] |=> DECODED.subtract == $past(INSTR_WORD[SUB_BIT])
	) else $error("offset sign not passed to address calc");
	a_store_load: assert property ( // see RQ2
		take_instr && (INSTR_WORD[2:0] == 3'h1 || INSTR_WORD[2:0] == 3'h4)
			|=> DECODED.is_mem && DECODED.is_store == $past(INSTR_WORD[STORE_BIT])
	) else $error("direction bit misdecoded");
	a_size_field: assert property ( // see RQ3
		DECODED.is_mem |-> DECODED.access_size_field == $past(INSTR_WORD[SIZE_LSB +: 2])
	) else $error("access size mismatch");
	a_group_base: assert property ( // see RQ4
		DECODED.is_special && DECODED.special_reg_group == 2'h1 |-> DECODED.special_base == GRP_BASE_DMA
	) else $error("special group base wrong");
	a_shift_amount: assert property ( // see RQ5
		take_instr && INSTR_WORD[2:0] == 3'h6 |=> DECODED.shift_amount_imm == $past(INSTR_WORD[9:5])
	) else $error("shift amount wrong");
	a_branch_disp: assert property ( // see RQ6
		take_instr && INSTR_WORD[3:0] == 4'h8 |=> DECODED.branch_displacement == $past(INSTR_WORD[31:8])
	) else $error("branch displacement wrong");
	a_cond_select: assert property ( // see RQ7
		take_instr && INSTR_WORD[2:0] == 3'h0 |=> DECODED.condition_select == $past(INSTR_WORD[7:4])
	) else $error("condition select wrong");
	a_cause_fpu: assert property ( // see RQ8, see RQ9
		FPU_EV && !UNALIGNED_EV && !ILLEGAL_EV && !take_instr |=> EXC_VALID && EXC_CAUSE == (GEN ? 4'h7 : 4'h3)
	) else $error("fpu cause code wrong");
	a_cause_unimpl: assert property ( // see RQ10
		take_instr && undefined_f(INSTR_WORD) |=> EXC_CAUSE == (GEN ? 4'hf : 4'h4) ##1 ist_q[EV_UNIMPL]
	) else $error("unimplemented not raised");
	a_length_bit: assert property ( // see RQ11
		take_instr |=> DECODED.valid && DECODED.is_long == $past(INSTR_WORD[3])
	) else $error("instruction length wrong");
	a_irq_level: assert property (
		(ist_q & ien_q) != '0 |=> IRQ
	) else $error("irq not raised");
	a_short_nosub: assert property ( // see RQ1
		take_instr && (INSTR_WORD[2:0] == 3'h1 || INSTR_WORD[2:0] == 3'h4) && !INSTR_WORD[LONG_BIT] |=> !DECODED.subtract
	) else $error("short access must add");
	a_group_core: assert property ( // see RQ4
		DECODED.is_special && DECODED.special_reg_group == 2'h0 |-> DECODED.special_base == GRP_BASE_CORE
	) else $error("core group base wrong");
	a_group_mpu: assert property ( // see RQ4
		DECODED.is_special && DECODED.special_reg_group == 2'h2 |-> DECODED.special_base == GRP_BASE_MPU
	) else $error("protection group base wrong");
	a_group_node: assert property ( // see RQ4
		DECODED.is_special && DECODED.special_reg_group == 2'h3 |-> DECODED.special_base == GRP_BASE_NODE
	) else $error("node group base wrong");
	a_short_disp: assert property ( // see RQ6
		take_instr && INSTR_WORD[3:0] == 4'h0 |=> DECODED.branch_displacement == {16'h0000, $past(INSTR_WORD[15:8])}
	) else $error("short branch displacement wrong");
	a_cause_swi: assert property ( // see RQ8, see RQ9
		take_instr && is_sys_f(INSTR_WORD) && INSTR_WORD[SYS_LSB +: 6] == SYS_TRAP
			|=> EXC_VALID && EXC_CAUSE == (GEN ? G1_SWI : G0_SWI)
	) else $error("swi cause code wrong");
	a_cause_unalgn: assert property ( // see RQ8, see RQ9
		UNALIGNED_EV && !take_instr |=> EXC_VALID && EXC_CAUSE == (GEN ? G1_UNALGN : G0_UNALGN)
	) else $error("unaligned cause code wrong");
	a_cause_illeg: assert property ( // see RQ8, see RQ9
		ILLEGAL_EV && !UNALIGNED_EV && !take_instr |=> EXC_VALID && EXC_CAUSE == (GEN ? G1_ILLEG : G0_ILLEG)
	) else $error("illegal access cause code wrong");
	a_cause_hold: assert property (
		ev_d == '0 |=> !EXC_VALID && $stable(EXC_CAUSE)
	) else $error("cause changed without an event");
	a_disabled_quiet: assert property (
		!ctrl_en_q |=> !DECODED.valid
	) else $error("word decoded while disabled");
	a_irq_low: assert property (
		(ist_q & ien_q) == '0 |=> !IRQ
	) else $error("irq without enabled status");
	a_ien_write: assert property (
		wr_pend_q && wr_addr_q == ADDR_IEN |=> ien_q == $past(HWDATA[NUM_EV-1:0])
	) else $error("enable write lost");

	c_store_long: cover property (DECODED.valid && DECODED.is_store && DECODED.is_long);
	c_swi_irq:    cover property (ev_d[EV_SWI] ##[1:4] IRQ);
	c_clear_race: cover property (wr_pend_q && wr_addr_q == ADDR_ICLR && |ev_d);
	c_long_branch: cover property (DECODED.valid && DECODED.iclass == CL_BRANCH && DECODED.is_long);
	c_event_burst: cover property (EXC_VALID ##1 EXC_VALID);
endmodule : rfd_decoder
`default_nettype wire

// file: bench/rfd_fetch_model.sv
// rfd_fetch_model: stands in for fetch logic and the execution pipeline
// assumes its tasks are entered just after a rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module rfd_fetch_model (
	input  wire logic        clk,
	output var  logic [31:0] word,
	output var  logic        valid,
	output var  logic [2:0]  ev
);
	initial begin
		word  = 32'h0;
		valid = 1'b0;
		ev    = 3'h0;
	end
	// valid stays up after a call, so calls run back to back
	task automatic send(input logic [31:0] w);
		word  <= w;
		valid <= 1'b1;
		@(posedge clk);
	endtask : send
	// a released word flips every cycle so stale data never looks held
	task automatic idle(input int n);
		valid <= 1'b0;
		repeat (n) begin
			word <= ~word;
			@(posedge clk);
		end
	endtask : idle
	// ev[0] unaligned, ev[1] illegal, ev[2] fpu; call idle between pulses
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		@(posedge clk);
		ev <= 3'h0;
	endtask : pulse
endmodule : rfd_fetch_model
`default_nettype wire

// file: bench/tb.sv
// tb: self-checking bench for rfd_decoder, both cause generations side by side
// assumes rfd_fetch_model feeds words and events; the bench is the AHB-Lite master
`timescale 1ns/1ps
`default_nettype none
module tb import rfd_pkg::*;;
	typedef struct {
		rfd_dec_t d;
		bit       full;
	} rfd_exp_t;
	logic        MCLK, RST_N, HWRITE, HREADYOUT, HRESP, INSTR_VALID, EXC_VALID, IRQ, exc_v1;
	logic        HSEL, sel, hrdy1, hresp1, irq1;
	logic [31:0] HADDR, HWDATA, HRDATA, INSTR_WORD, rd, w, hrdata1, rd1;
	logic [1:0]  HTRANS;
	logic [2:0]  ev, HSIZE;
	logic [3:0]  EXC_CAUSE, cause1;
	rfd_dec_t    DECODED, dec1;
	rfd_exp_t    dq[$];
	rfd_exp_t    ex;
	int          eq[$];
	int          ei, error_cnt, n_checks, seed;
	logic [3:0]  c0 [0:4] = '{4'h4, 4'h1, 4'h2, 4'h5, 4'h3};
	logic [3:0]  c1 [0:4] = '{4'hf, 4'he, 4'hd, 4'hc, 4'h7};
	logic [31:0] dir [0:12] = '{32'h1c, 32'h10003c, 32'h5c, 32'h10007c, 32'h69, 32'h10a, 32'h10010a,
		32'h20010a, 32'h30010a, 32'h300102, 32'h3e6, 32'hfffffff8, 32'hfff0};

	rfd_decoder #(.GEN(1'b0)) dut_u (.MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .INSTR_WORD(INSTR_WORD), .INSTR_VALID(INSTR_VALID),
		.UNALIGNED_EV(ev[0]), .ILLEGAL_EV(ev[1]), .FPU_EV(ev[2]), .DECODED(DECODED),
		.EXC_VALID(EXC_VALID), .EXC_CAUSE(EXC_CAUSE), .IRQ(IRQ));
	rfd_decoder #(.GEN(1'b1)) gen1_u (.MCLK(MCLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(hrdata1),
		.HREADYOUT(hrdy1), .HRESP(hresp1), .INSTR_WORD(INSTR_WORD), .INSTR_VALID(INSTR_VALID),
		.UNALIGNED_EV(ev[0]), .ILLEGAL_EV(ev[1]), .FPU_EV(ev[2]), .DECODED(dec1), .EXC_VALID(exc_v1),
		.EXC_CAUSE(cause1), .IRQ(irq1));
	rfd_fetch_model fm_u (.clk(MCLK), .word(INSTR_WORD), .valid(INSTR_VALID), .ev(ev));

	initial begin
		MCLK = 1'b0;
		forever #12.5 MCLK = ~MCLK;
	end
	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		n_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic stop_test();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		HSEL   <= sel;
		HSIZE  <= 3'h2;
		HTRANS <= 2'h2;
		HADDR  <= {24'h0, a};
		HWRITE <= wr;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
		rd1 = hrdata1;
		chk({HRESP, hresp1, hrdy1}, 3'b001);
	endtask : bus
	// the later generation differs only in its cause codes
	task automatic rdx(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
		if (a != ADDR_CAUSE) chk(rd1, e);
	endtask : rdx
	// expected fields, zero where a class does not use them
	function automatic rfd_dec_t exp_dec(input logic [31:0] x);
		rfd_dec_t d;
		d = '0;
		d.valid = 1'b1;
		d.is_long = x[3];
		d.iclass = rfd_class_t'(x[2:0]);
		if (x[2:0] == 3'h1 || x[2:0] == 3'h4) begin
			d.is_mem = 1'b1;
			d.is_store = x[4];
			d.access_size_field = x[6:5];
			d.subtract = x[3] & x[20];
		end
		if (x[2:0] == 3'h6) d.shift_amount_imm = x[9:5];
		if (x[2:0] == 3'h0) d.branch_displacement = x[3] ? x[31:8] : {16'h0, x[15:8]};
		if (x[2:0] == 3'h0 || (x[2:0] == 3'h2 && !x[8])) d.condition_select = x[7:4];
		if (x[2:0] == 3'h2 && x[8]) begin
			d.is_special = 1'b1;
			d.special_reg_group = x[3] ? x[21:20] : 2'h0;
			d.special_base = 12'hf04 + {10'h0, d.special_reg_group};
		end
		return d;
	endfunction : exp_dec
	task automatic snd(input logic [31:0] x, input bit full);
		dq.push_back('{exp_dec(x), full});
		fm_u.send(x);
	endtask : snd
	// ----------------------------------------
	// output watcher
	// ----------------------------------------
	always @(posedge MCLK) begin
		if (DECODED.valid === 1'b1) begin
			if (dq.size() == 0) chk(1, 0);
			else begin
				ex = dq.pop_front();
				if (ex.full) chk(DECODED, ex.d);
				else chk(DECODED.valid, 1'b1);
				if (ex.full) chk(dec1, ex.d);
				else chk(dec1.valid, 1'b1);
			end
		end
		if (EXC_VALID === 1'b1) begin
			if (eq.size() == 0) chk(1, 0);
			else begin
				ei = eq.pop_front();
				chk(EXC_CAUSE, c0[ei]);
				chk({exc_v1, cause1}, {1'b1, c1[ei]});
			end
		end
	end
	initial begin
		repeat (6000) @(posedge MCLK);
		error_cnt++;
		stop_test();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		RST_N  = 1'b0;
		HADDR  = 32'h0;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HWDATA = 32'h0;
		HSEL   = 1'b0;
		HSIZE  = 3'h0;
		sel    = 1'b1;
		seed = $urandom(31);
		repeat (4) @(posedge MCLK);
		RST_N <= 1'b1;
		repeat (2) @(posedge MCLK);
		rdx(ADDR_CTRL, 32'h1);
		rdx(ADDR_IEN, 32'h0);
		bus(1'b1, 8'h20, 32'hffffffff);
		rdx(8'h20, 32'h0);
		// a deselected write must not land
		sel = 1'b0;
		bus(1'b1, ADDR_IEN, 32'h1f);
		sel = 1'b1;
		rdx(ADDR_IEN, 32'h0);
		foreach (dir[k]) snd(dir[k], 1'b1);
		repeat (40) begin
			w = $urandom;
			if (w[3:0] == 4'hd) w[19:16] = 4'ha;
			if (w[3:0] == 4'h2 && w[9:8] == 2'h3) w[9] = 1'b0;
			snd(w, 1'b1);
		end
		// undefined words and a trap back to back, then pipeline events
		eq = '{0, 0, 1};
		snd(32'h302, 1'b0);
		snd(32'hd, 1'b0);
		snd(32'h3e2, 1'b0);
		fm_u.idle(2);
		for (int k = 0; k < 3; k++) begin
			eq.push_back(k + 2);
			fm_u.pulse(k);
			fm_u.idle(2);
		end
		rdx(ADDR_CAUSE, 32'h00030000);
		chk(rd1, 32'h00070000);
		rdx(ADDR_ISTAT, 32'h1f);
		chk({IRQ, irq1}, 2'b00);
		bus(1'b1, ADDR_IEN, 32'h10);
		repeat (2) @(posedge MCLK);
		chk({IRQ, irq1}, 2'b11);
		bus(1'b1, ADDR_ICLR, 32'h10);
		repeat (2) @(posedge MCLK);
		chk({IRQ, irq1}, 2'b00);
		rdx(ADDR_ISTAT, 32'h0f);
		eq.push_back(4);
		fm_u.pulse(2);
		fm_u.idle(2);
		chk({IRQ, irq1}, 2'b11);
		bus(1'b1, ADDR_IEN, 32'h0);
		repeat (2) @(posedge MCLK);
		chk({IRQ, irq1}, 2'b00);
		bus(1'b1, ADDR_ICLR, 32'h1f);
		rdx(ADDR_ISTAT, 32'h0);
		// decode switched off: the word must leave no trace
		bus(1'b1, ADDR_CTRL, 32'h0);
		fm_u.send(32'h302);
		fm_u.idle(3);
		rdx(ADDR_LAST, 32'h3e2);
		rdx(ADDR_ISTAT, 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h1);
		// reset in mid-run restores register defaults
		bus(1'b1, ADDR_IEN, 32'h3);
		RST_N <= 1'b0;
		repeat (2) @(posedge MCLK);
		RST_N <= 1'b1;
		repeat (2) @(posedge MCLK);
		rdx(ADDR_IEN, 32'h0);
		rdx(ADDR_CTRL, 32'h1);
		chk(dq.size() + eq.size(), 0);
		stop_test();
	end
endmodule : tb
`default_nettype wire
